// File: rtl/civm_defs.svh
// Purpose: offsets, reset values and vectors of the interrupt vectoring block
// Assumes: 8-bit register port, 3-bit word address
// Notes: definitions only
`ifndef CIVM_DEFS_SVH
`define CIVM_DEFS_SVH

// register offsets
`define CIVM_OFS_TIMER_EN   3'h0
`define CIVM_OFS_PERIPH_EN  3'h1
`define CIVM_OFS_PROMOTE    3'h2
`define CIVM_OFS_SYSCTL     3'h3
`define CIVM_OFS_STATUS     3'h4
`define CIVM_OFS_SERIAL_EN  3'h5

// reset values
`define CIVM_RST_PROMOTE    4'h5
`define CIVM_RST_EN         8'h00

// vector locations, high byte at the even address
`define CIVM_VEC_I_BASE     16'hffd6
`define CIVM_VEC_PSEUDO_NMI 16'hfff4
`define CIVM_VEC_SOFT_TRAP  16'hfff6
`define CIVM_VEC_ILLEGAL    16'hfff8
`define CIVM_VEC_WATCHDOG   16'hfffa
`define CIVM_VEC_CLKMON     16'hfffc

// number of I-masked vector slots
`define CIVM_NUM_I_SRC      15
`define CIVM_IDX_EXT_PIN    4'he

`endif

// File: rtl/civm_pkg.sv
// Purpose: types shared by the interrupt vectoring block
// Assumes: nothing
// Notes: constants live in civm_defs.svh
package civm_pkg;

   // raw requests from the on-chip sources and pins
   typedef struct packed {
      logic ext_pin;
      logic handshake;
      logic periodic_tick;
      logic [2:0] capture;  // [0] is capture 1
      logic [4:0] compare;  // [0] is compare 1
      logic timer_ovf;
      logic pulse_ovf;
      logic pulse_edge;
      logic sync_serial;
      logic rx_full;
      logic rx_overrun;
      logic idle_line;
      logic tx_empty;
      logic tx_complete;
   } civm_src_s;

   // interrupt mask bits of the condition code register
   typedef struct packed {
      logic x;
      logic i;
   } civm_ccr_s;

   typedef enum logic [1:0] {
      CIVM_RUN,
      CIVM_STACK,
      CIVM_FETCH,
      CIVM_TRAP
   } civm_state_e;

endpackage

// File: rtl/civm_core.sv
// Purpose: interrupt acceptance, priority, masking and vectoring
// Assumes: sequencer gives boundary, stacking and fetch strobes
// Notes: vector_o is the even address holding the high byte
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "civm_defs.svh"

module civm_core
   import civm_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // request sources
   input wire civm_src_s src_i,
   input wire logic pseudo_nmi_pin_i,
   input wire logic illegal_op_i,
   input wire logic watchdog_fail_i,
   input wire logic clock_fail_i,
   // sequencer strobes
   input wire logic instr_done_i,
   input wire logic soft_trap_instr_i,
   input wire logic cc_stacked_i,
   input wire logic vec_fetched_i,
   input wire logic return_from_trap_instr_i,
   input wire civm_ccr_s unstacked_ccr_i,
   input wire logic ccr_load_i,
   input wire civm_ccr_s ccr_load_val_i,
   // sequencer answers
   output logic pending_o,
   output logic take_o,
   output logic [15:0] vector_o,
   output civm_ccr_s condition_code_reg_o
);

   // map a promote code onto an I-masked slot index
   function automatic logic [3:0] promote_slot(input logic [3:0] sel);
      logic [3:0] s;
      s = `CIVM_IDX_EXT_PIN;
      unique case (sel)
         4'h0: s = 4'h4;
         4'h1: s = 4'h3;
         4'h2: s = 4'h2;
         4'h3: s = 4'h1;
         4'h4: s = 4'h0;
         4'h5, 4'h6: s = `CIVM_IDX_EXT_PIN;
         4'h7: s = 4'hd;
         4'h8: s = 4'hc;
         4'h9: s = 4'hb;
         4'ha: s = 4'ha;
         4'hb: s = 4'h9;
         4'hc: s = 4'h8;
         4'hd: s = 4'h7;
         4'he: s = 4'h6;
         4'hf: s = 4'h5;
      endcase
      return s;
   endfunction

   // slot index to even vector address
   function automatic logic [15:0] slot_vector(input logic [3:0] k);
      return `CIVM_VEC_I_BASE + {11'h000, k, 1'b0};
   endfunction

   civm_state_e state_q, state_d;
   civm_ccr_s ccr_q, ccr_d;
   logic [7:0] timer_en_q, periph_en_q, serial_en_q;
   logic [3:0] promote_q;
   logic watchdog_disable_q, clock_monitor_enable_q;
   logic pseudo_nmi_pin_entry_q;
   logic take_q;
   logic [15:0] vector_q;
   logic [7:0] rdata_q;

   // local enables by name; compare and capture hits gated at once
   wire logic [4:0] cmp_on = src_i.compare & timer_en_q[4:0];
   wire logic [2:0] cap_on = src_i.capture & timer_en_q[7:5];
   wire logic timer_overflow_irq_enable = periph_en_q[0];
   wire logic pulse_overflow_irq_enable = periph_en_q[1];
   wire logic pulse_edge_irq_enable = periph_en_q[2];
   wire logic sync_serial_irq_enable = periph_en_q[3];
   wire logic periodic_tick_irq_enable = periph_en_q[4];
   wire logic handshake_irq_enable = periph_en_q[5];
   wire logic receive_irq_enable = serial_en_q[0];
   wire logic idle_line_irq_enable = serial_en_q[1];
   wire logic tx_empty_irq_enable = serial_en_q[2];
   wire logic tx_complete_irq_enable = serial_en_q[3];

   // serial causes folded onto one vector
   wire logic serial_req = ((src_i.rx_full | src_i.rx_overrun)
      & receive_irq_enable) | (src_i.idle_line & idle_line_irq_enable)
      | (src_i.tx_empty & tx_empty_irq_enable)
      | (src_i.tx_complete & tx_complete_irq_enable);

   // I-masked slots, index k vectors at base plus 2k
   wire logic [14:0] slot_req = {
      src_i.ext_pin | (src_i.handshake & handshake_irq_enable),
      src_i.periodic_tick & periodic_tick_irq_enable,
      cap_on[0], cap_on[1], cap_on[2],  // capture 1 on the higher slot
      cmp_on[0], cmp_on[1], cmp_on[2], cmp_on[3], cmp_on[4],
      src_i.timer_ovf & timer_overflow_irq_enable,
      src_i.pulse_ovf & pulse_overflow_irq_enable,
      src_i.pulse_edge & pulse_edge_irq_enable,
      src_i.sync_serial & sync_serial_irq_enable,
      serial_req};

   // I gating of the slots
   wire logic [14:0] slot_live = slot_req & {15{~ccr_q.i}};
   wire logic [3:0] promo_k = promote_slot(promote_q);
   wire logic promo_hit = slot_live[promo_k];

   // fixed order among I slots, highest index first
   logic [3:0] fixed_k;
   always_comb begin
      fixed_k = 4'h0;
      for (int k = 0; k < `CIVM_NUM_I_SRC; k++) begin
         if (slot_live[k]) begin
            fixed_k = 4'(k);
         end
      end
   end

   // non-I sources
   wire logic clkmon_req = clock_fail_i & clock_monitor_enable_q;
   wire logic wdog_req = watchdog_fail_i & ~watchdog_disable_q;
   wire logic pseudo_nmi_pin_req = pseudo_nmi_pin_i & ~ccr_q.x;
   wire logic any_req = clkmon_req | wdog_req | illegal_op_i
      | pseudo_nmi_pin_req | (|slot_live);

   // winning vector; non-I order then promoted then fixed
   wire logic [15:0] win_vec =
      clkmon_req   ? `CIVM_VEC_CLKMON :
      wdog_req     ? `CIVM_VEC_WATCHDOG :
      illegal_op_i ? `CIVM_VEC_ILLEGAL :
      pseudo_nmi_pin_req     ? `CIVM_VEC_PSEUDO_NMI :
      promo_hit    ? slot_vector(promo_k) :
      slot_vector(fixed_k);

   // accept only at an instruction boundary while running
   wire logic accept = (state_q == CIVM_RUN) & instr_done_i & any_req;
   wire logic trap_start = (state_q == CIVM_RUN) & soft_trap_instr_i
      & ~accept;

   // register decode
   wire logic wr_timer = reg_wr_i & (reg_addr_i == `CIVM_OFS_TIMER_EN);
   wire logic wr_periph = reg_wr_i & (reg_addr_i == `CIVM_OFS_PERIPH_EN);
   wire logic wr_serial = reg_wr_i & (reg_addr_i == `CIVM_OFS_SERIAL_EN);
   wire logic wr_promote = reg_wr_i & (reg_addr_i == `CIVM_OFS_PROMOTE)
      & ccr_q.i;
   wire logic wr_sysctl = reg_wr_i & (reg_addr_i == `CIVM_OFS_SYSCTL);

   // read mux, unmapped reads give zero
   logic [7:0] rd_mux;
   always_comb begin
      unique case (reg_addr_i)
         `CIVM_OFS_TIMER_EN: rd_mux = timer_en_q;
         `CIVM_OFS_PERIPH_EN: rd_mux = periph_en_q;
         `CIVM_OFS_SERIAL_EN: rd_mux = serial_en_q;
         `CIVM_OFS_PROMOTE: rd_mux = {4'h0, promote_q};
         `CIVM_OFS_SYSCTL: rd_mux = {6'h00, clock_monitor_enable_q,
            watchdog_disable_q};
         `CIVM_OFS_STATUS: rd_mux = {3'h0, any_req, state_q, ccr_q};
         default: rd_mux = 8'h00;
      endcase
   end

   // sequencing of entry
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CIVM_RUN: begin
            if (accept) begin
               state_d = CIVM_STACK;
            end else if (trap_start) begin
               state_d = CIVM_TRAP;
            end
         end
         CIVM_STACK, CIVM_TRAP: begin
            if (cc_stacked_i) begin
               state_d = CIVM_FETCH;
            end
         end
         CIVM_FETCH: begin
            if (vec_fetched_i) begin
               state_d = CIVM_RUN;
            end
         end
      endcase
   end

   // mask bit updates
   always_comb begin
      ccr_d = ccr_q;
      if (return_from_trap_instr_i) begin
         ccr_d = unstacked_ccr_i;
      end else if (ccr_load_i) begin
         ccr_d.i = ccr_load_val_i.i;
         ccr_d.x = ccr_q.x & ccr_load_val_i.x;
      end
      if (cc_stacked_i && state_q != CIVM_RUN
         && state_q != CIVM_FETCH) begin
         ccr_d.i = 1'b1;
         if (pseudo_nmi_pin_entry_q) begin
            ccr_d.x = 1'b1;
         end
      end
   end

   // state and mask flops
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= CIVM_RUN;
         ccr_q <= '{x: 1'b1, i: 1'b1};
      end else begin
         state_q <= state_d;
         ccr_q <= ccr_d;
      end
   end

   // vector capture at acceptance or soft trap start
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         take_q <= 1'b0;
         vector_q <= 16'h0000;
         pseudo_nmi_pin_entry_q <= 1'b0;
      end else begin
         take_q <= accept | trap_start;
         if (accept) begin
            vector_q <= win_vec;
            pseudo_nmi_pin_entry_q <= win_vec == `CIVM_VEC_PSEUDO_NMI;
         end else if (trap_start) begin
            vector_q <= `CIVM_VEC_SOFT_TRAP;
            pseudo_nmi_pin_entry_q <= 1'b0;
         end
      end
   end

   // software registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_en_q <= `CIVM_RST_EN;
         periph_en_q <= `CIVM_RST_EN;
         serial_en_q <= `CIVM_RST_EN;
         promote_q <= `CIVM_RST_PROMOTE;
         watchdog_disable_q <= 1'b0;
         clock_monitor_enable_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         if (wr_timer) timer_en_q <= reg_wdata_i;
         if (wr_periph) periph_en_q <= reg_wdata_i;
         if (wr_serial) serial_en_q <= reg_wdata_i;
         if (wr_promote) promote_q <= reg_wdata_i[3:0];
         if (wr_sysctl) watchdog_disable_q <= reg_wdata_i[0];
         if (wr_sysctl) clock_monitor_enable_q <= reg_wdata_i[1];
         rdata_q <= reg_rd_i ? rd_mux : 8'h00;
      end
   end

   // outputs
   assign pending_o = any_req;
   assign take_o = take_q;
   assign vector_o = vector_q;
   assign condition_code_reg_o = ccr_q;
   assign reg_rdata_o = rdata_q;

   // checks
   property p_boundary;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == CIVM_RUN && any_req && !instr_done_i) |=>
         (state_q == CIVM_RUN || $past(soft_trap_instr_i));
   endproperty
   a_boundary: assert property (p_boundary)
      else $error("request taken off a boundary");

   property p_pseudo_nmi_pin_first;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (accept && pseudo_nmi_pin_req && !illegal_op_i && !wdog_req && !clkmon_req)
         |=> take_o && vector_o == 16'hfff4;
   endproperty
   a_pseudo_nmi_pin_first: assert property (p_pseudo_nmi_pin_first)
      else $error("pseudo nmi not on top of I sources");

   property p_i_gate;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (accept && ccr_q.i) |=> vector_o >= 16'hfff4;
   endproperty
   a_i_gate: assert property (p_i_gate)
      else $error("I-masked vector taken with I set");

   property p_promote_lock;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_wr_i && reg_addr_i == 3'h2 && !ccr_q.i) |=> $stable(promote_q);
   endproperty
   a_promote_lock: assert property (p_promote_lock)
      else $error("promote select changed with I clear");

   property p_x_no_set;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!ccr_q.x && !return_from_trap_instr_i && !pseudo_nmi_pin_entry_q) |=> !ccr_q.x;
   endproperty
   a_x_no_set: assert property (p_x_no_set)
      else $error("X set by software");

   sequence s_entry;
      state_q != CIVM_RUN && state_q != CIVM_FETCH && !pseudo_nmi_pin_entry_q;
   endsequence
   property p_i_entry;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_entry ##0 (cc_stacked_i && !return_from_trap_instr_i && !ccr_load_i)
         |=> ccr_q.i && ccr_q.x == $past(ccr_q.x);
   endproperty
   a_i_entry: assert property (p_i_entry)
      else $error("I entry mask update wrong");

   property p_x_entry;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == CIVM_STACK && pseudo_nmi_pin_entry_q && cc_stacked_i
         && !return_from_trap_instr_i) |=> ccr_q.x && ccr_q.i;
   endproperty
   a_x_entry: assert property (p_x_entry)
      else $error("X entry mask update wrong");

   property p_trap_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == CIVM_TRAP || state_q == CIVM_FETCH) |=> !take_o;
   endproperty
   a_trap_hold: assert property (p_trap_hold)
      else $error("accept during soft trap");

   property p_rti;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      return_from_trap_instr_i && !cc_stacked_i
         |=> ccr_q == $past(unstacked_ccr_i);
   endproperty
   a_rti: assert property (p_rti)
      else $error("return did not restore masks");

endmodule // civm_core

// File: testbench/civm_seq_model.sv
// Purpose: instruction sequencer stand-in facing the vectoring block
// Assumes: one clock, boundaries every few cycles
// Notes: slow_i stretches every step of the sequence
`timescale 1ns/10ps
module civm_seq_model
   import civm_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // bench requests
   input wire logic slow_i,
   input wire logic trap_req_i,
   input wire logic rti_req_i,
   // block answers
   input wire logic pending_i,
   input wire logic take_i,
   input wire civm_ccr_s ccr_i,
   // strobes to the block
   output logic instr_done_o,
   output logic soft_trap_o,
   output logic cc_stacked_o,
   output logic vec_fetched_o,
   output logic rti_o,
   output civm_ccr_s stacked_o
);
   logic busy_q;
   logic trap_q;
   logic [3:0] cnt_q;
   wire logic [3:0] step_w = slow_i ? 4'h5 : 4'h2;
   wire logic bound_w = !busy_q && (cnt_q == step_w);

   // boundary, stacking and fetch steps
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         trap_q <= 1'b0;
         cnt_q <= 4'h0;
         instr_done_o <= 1'b0;
         soft_trap_o <= 1'b0;
         cc_stacked_o <= 1'b0;
         vec_fetched_o <= 1'b0;
         rti_o <= 1'b0;
         stacked_o <= '0;
      end else begin
         instr_done_o <= 1'b0;
         soft_trap_o <= 1'b0;
         cc_stacked_o <= 1'b0;
         vec_fetched_o <= 1'b0;
         rti_o <= rti_req_i;
         cnt_q <= cnt_q + 4'h1;
         if (trap_req_i) trap_q <= 1'b1;
         if (take_i) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
         end else if (bound_w) begin
            cnt_q <= 4'h0;
            // trap opcode held back while a request waits
            if (trap_q && !pending_i) begin
               soft_trap_o <= 1'b1;
               trap_q <= 1'b0;
            end else begin
               instr_done_o <= 1'b1;
            end
         end else if (busy_q && cnt_q == step_w) begin
            cc_stacked_o <= 1'b1;
            stacked_o <= ccr_i;
         end else if (busy_q && cnt_q == step_w + step_w) begin
            vec_fetched_o <= 1'b1;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
         end
      end
   end
endmodule // civm_seq_model

// File: testbench/civm_core_bench.sv
// Purpose: self-checking bench for the interrupt vectoring block
// Assumes: sequencer model paces boundaries and stacking
// Notes: every entry is returned from, restoring x and i
`timescale 1ns/10ps
`include "civm_defs.svh"
module civm_core_bench
   import civm_pkg::*;
;
   logic core_clk;
   logic rst_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr, rd, nmi, ill, wdf, ckf, ld, slow, trap_req, rti_req;
   logic pending, take, done, strap, stacked, fetched, return_from_trap_instr;
   logic [15:0] vector;
   civm_src_s src;
   civm_ccr_s ld_val, condition_code_reg, unstacked;
   int n_mismatch = 0;
   int n_checks = 0;

   // block and sequencer
   civm_core dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .src_i(src), .pseudo_nmi_pin_i(nmi),
      .illegal_op_i(ill), .watchdog_fail_i(wdf), .clock_fail_i(ckf),
      .instr_done_i(done), .soft_trap_instr_i(strap),
      .cc_stacked_i(stacked), .vec_fetched_i(fetched),
      .return_from_trap_instr_i(return_from_trap_instr), .unstacked_ccr_i(unstacked),
      .ccr_load_i(ld), .ccr_load_val_i(ld_val), .pending_o(pending),
      .take_o(take), .vector_o(vector), .condition_code_reg_o(condition_code_reg));
   civm_seq_model seq_u (.core_clk_i(core_clk), .rst_n_i(rst_n),
      .slow_i(slow), .trap_req_i(trap_req), .rti_req_i(rti_req),
      .pending_i(pending), .take_i(take), .ccr_i(condition_code_reg),
      .instr_done_o(done), .soft_trap_o(strap), .cc_stacked_o(stacked),
      .vec_fetched_o(fetched), .rti_o(return_from_trap_instr), .stacked_o(unstacked));

   // 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk({8'h0, rdata}, {8'h0, e});
   endtask

   task automatic ld_ccr(input logic x, input logic i);
      @(posedge core_clk);
      ld <= 1'b1;
      ld_val <= {x, i};
      @(posedge core_clk);
      ld <= 1'b0;
   endtask

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         chk({14'h0, take, pending}, 16'h0);
      end
   endtask

   // one entry: take, vector, mask update, return
   task automatic serve(input logic [15:0] v, input logic [1:0] c);
      civm_ccr_s pre;
      logic prev;
      int k;
      #1;
      pre = condition_code_reg;
      k = 0;
      do begin
         prev = done | strap;
         @(posedge core_clk);
         #1;
         k++;
      end while (take !== 1'b1 && k < 60);
      chk({15'h0, take}, 16'h1);
      if (take !== 1'b1) return;
      chk({15'h0, prev}, 16'h1);
      chk(vector, v);
      @(posedge core_clk);
      {src, nmi, ill, wdf, ckf} <= '0;
      #1;
      k = 0;
      while (fetched !== 1'b1 && k < 60) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk({15'h0, fetched}, 16'h1);
      @(posedge core_clk);
      #1;
      chk({14'h0, condition_code_reg}, {14'h0, c});
      @(posedge core_clk);
      rti_req <= 1'b1;
      @(posedge core_clk);
      rti_req <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({14'h0, condition_code_reg}, {14'h0, pre});
   endtask

   function automatic logic [15:0] vec_of(input int k);
      if (k < 5) return 16'hffd6;
      if (k < 9) return 16'hffd8 + 16'(2 * (k - 5));
      if (k < 14) return 16'hffe8 - 16'(2 * (k - 9));
      if (k < 17) return 16'hffee - 16'(2 * (k - 14));
      if (k == 17) return 16'hfff0;
      return 16'hfff2;
   endfunction

   task automatic s_mask();
      ld_ccr(1'b0, 1'b0);
      ld_ccr(1'b1, 1'b1);
      src.timer_ovf <= 1'b1;
      #1;
      chk({14'h0, condition_code_reg}, 16'h1);
      wr_reg(`CIVM_OFS_PERIPH_EN, 8'h01);
      quiet(8);
      wr_reg(`CIVM_OFS_PERIPH_EN, 8'h00);
      ld_ccr(1'b0, 1'b0);
      slow <= 1'b1;
      quiet(8);
      wr_reg(`CIVM_OFS_PERIPH_EN, 8'h01);
      serve(16'hffde, 2'b01);
   endtask

   task automatic s_vectors();
      wr_reg(`CIVM_OFS_TIMER_EN, 8'hff);
      wr_reg(`CIVM_OFS_PERIPH_EN, 8'h3f);
      wr_reg(`CIVM_OFS_SERIAL_EN, 8'h0f);
      for (int k = 0; k < 20; k++) begin
         @(posedge core_clk);
         src <= civm_src_s'(20'h00001 << k);
         slow <= 1'(k % 2);
         serve(vec_of(k), 2'b01);
      end
      wr_reg(`CIVM_OFS_SERIAL_EN, 8'h0e);
      src.rx_full <= 1'b1;
      quiet(8);
   endtask

   task automatic s_promote();
      @(posedge core_clk);
      src.ext_pin <= 1'b1;
      src.timer_ovf <= 1'b1;
      serve(16'hfff2, 2'b01);
      wr_reg(`CIVM_OFS_PROMOTE, 8'h00);
      rd_reg(`CIVM_OFS_PROMOTE, 8'h05);
      ld_ccr(1'b0, 1'b1);
      wr_reg(`CIVM_OFS_PROMOTE, 8'h00);
      rd_reg(`CIVM_OFS_PROMOTE, 8'h00);
      ld_ccr(1'b0, 1'b0);
      src.ext_pin <= 1'b1;
      src.timer_ovf <= 1'b1;
      serve(16'hffde, 2'b01);
   endtask

   task automatic s_nmi();
      @(posedge core_clk);
      nmi <= 1'b1;
      src.ext_pin <= 1'b1;
      serve(16'hfff4, 2'b11);
      @(posedge core_clk);
      nmi <= 1'b1;
      ill <= 1'b1;
      serve(16'hfff8, 2'b01);
      ld_ccr(1'b0, 1'b1);
      wdf <= 1'b1;
      serve(16'hfffa, 2'b01);
      wr_reg(`CIVM_OFS_SYSCTL, 8'h01);
      wdf <= 1'b1;
      ckf <= 1'b1;
      quiet(8);
      wr_reg(`CIVM_OFS_SYSCTL, 8'h02);
      ill <= 1'b1;
      serve(16'hfffc, 2'b01);
   endtask

   task automatic s_trap();
      ld_ccr(1'b0, 1'b0);
      trap_req <= 1'b1;
      @(posedge core_clk);
      trap_req <= 1'b0;
      serve(16'hfff6, 2'b01);
   endtask

   // reset, then the scenarios in turn
   initial begin
      {addr, wdata, wr, rd, nmi, ill, wdf, ckf, ld, slow} = '0;
      {trap_req, rti_req, src, ld_val} = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk({14'h0, condition_code_reg}, 16'h3);
      rd_reg(`CIVM_OFS_PROMOTE, 8'h05);
      rd_reg(`CIVM_OFS_PERIPH_EN, 8'h00);
      rd_reg(`CIVM_OFS_STATUS, 8'h03);
      wr_reg(3'h7, 8'hff);
      rd_reg(3'h7, 8'h00);
      s_mask();
      s_vectors();
      s_promote();
      s_nmi();
      s_trap();
      conclude();
   end
endmodule // civm_core_bench
